// *** common/ubrg_regs.vh ***
// Register offsets, field positions and reset values of the rate generator
// ============================================================
`ifndef UBRG_REGS_VH
`define UBRG_REGS_VH
// ============================================================
// Offsets per instance block, the instance stride and the port disable register
`define UBRG_OFF_TXSC     4'h0
`define UBRG_OFF_RXSC     4'h4
`define UBRG_OFF_RATE     4'h8
`define UBRG_OFF_DIVH     4'hC
`define UBRG_INST_STRIDE  8'h10
`define UBRG_OFF_PDIS     8'h20
// ============================================================
// Field positions
`define UBRG_TXSC_SYNC    4
`define UBRG_TXSC_HSPD    2
`define UBRG_TXSC_TSRE    1
`define UBRG_RXSC_SPEN    7
`define UBRG_RATE_WIDE    3
`define UBRG_RATE_IDLE    6
`define UBRG_RATE_RXINV   5
`define UBRG_DIVH_SHIFT   8
// ============================================================
// Reset values and write masks
`define UBRG_TXSC_RST     8'h02
`define UBRG_RXSC_RST     8'h00
`define UBRG_RATE_RST     8'h40
`define UBRG_TXSC_WMASK   8'hFD
`define UBRG_RXSC_WMASK   8'hF8
`define UBRG_RATE_WMASK   8'h3B
`define UBRG_PDIS_RST     8'h00
// ============================================================
// Prescale factors and sample count
`define UBRG_PRE_64       7'h40
`define UBRG_PRE_16       7'h10
`define UBRG_PRE_4        7'h04
`define UBRG_SMP_COUNT    3
`endif

// *** logic/ubrg_top.v ***
// Dual serial port rate generator with majority receive sampling
//
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "ubrg_regs.vh"

module ubrg_top #(
  parameter NUM_PORTS = 2
) (
  input  wire                 ref_clk,
  input  wire                 reset,
  input  wire                 psel,
  input  wire                 penable,
  input  wire                 pwrite,
  input  wire [7:0]           paddr,
  input  wire [31:0]          pwdata,
  output wire                 pready,
  output wire                 pslverr,
  output reg  [31:0]          prdata,
  input  wire [NUM_PORTS-1:0] receive_pin,
  output reg  [NUM_PORTS-1:0] rate_tick,
  output reg  [NUM_PORTS-1:0] sample_tick,
  output reg  [NUM_PORTS-1:0] rx_level
);

  // ============================================================
  // Bus decode
  wire       acc_w = psel & penable & pwrite;
  wire [3:0] reg_off = {paddr[3:2], 2'b00};
  wire       in_ports = (paddr < `UBRG_OFF_PDIS);
  wire       is_pdis = (paddr == `UBRG_OFF_PDIS);
  wire       mapped = (in_ports & (paddr[1:0] == 2'b00)) | is_pdis;
  wire [0:0] sel_port = paddr[4];

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  reg [7:0] pdis_q;
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pdis_q <= `UBRG_PDIS_RST;
    end else if (acc_w & is_pdis) begin
      pdis_q <= pwdata[7:0];
    end
  end

  // Prescale from mode bits
  function [6:0] pre_sel;
    input sync_m;
    input wide_m;
    input hs_m;
    begin
      if (sync_m) begin
        pre_sel = `UBRG_PRE_4;
      end else if (!wide_m && !hs_m) begin
        pre_sel = `UBRG_PRE_64;
      end else if (wide_m && hs_m) begin
        pre_sel = `UBRG_PRE_4;
      end else begin
        pre_sel = `UBRG_PRE_16;
      end
    end
  endfunction

  wire [7:0]  txsc_v [0:NUM_PORTS-1];
  wire [7:0]  rxsc_v [0:NUM_PORTS-1];
  wire [7:0]  rate_v [0:NUM_PORTS-1];
  wire [15:0] div_v  [0:NUM_PORTS-1];

  // ============================================================
  // Per-port logic
  genvar g;
  generate
    for (g = 0; g < NUM_PORTS; g = g + 1) begin : port
      wire       hit = acc_w & in_ports & (sel_port == g);
      wire       w_tx = hit & (reg_off == `UBRG_OFF_TXSC);
      wire       w_rx = hit & (reg_off == `UBRG_OFF_RXSC);
      wire       w_rt = hit & (reg_off == `UBRG_OFF_RATE);
      wire       w_dv = hit & (reg_off == `UBRG_OFF_DIVH);
      reg  [7:0] txsc_q;
      reg  [7:0] rxsc_q;
      reg  [7:0] rate_q;
      reg  [15:0] div_q;
      reg  [15:0] cnt_q;
      reg  [6:0]  pre_q;
      reg  [1:0]  smp_q;
      reg  [2:0]  vote_q;
      wire        en = rxsc_q[`UBRG_RXSC_SPEN] & ~pdis_q[3 + g];
      wire        wide = rate_q[`UBRG_RATE_WIDE];
      wire [6:0]  pre = pre_sel(txsc_q[`UBRG_TXSC_SYNC], wide,
                                txsc_q[`UBRG_TXSC_HSPD]);
      // Low byte only unless wide mode
      wire [15:0] n = wide ? div_q : {8'h00, div_q[7:0]};
      wire        pre_end = (pre_q == pre - 7'h01);
      wire        cnt_end = (cnt_q == 16'h0000);
      // Three sample points, all below the prescale end so none is lost
      wire [6:0]  smp_pt = {2'b00, pre[6:2]} * {5'h00, smp_q};
      wire [15:0] div_nx = w_dv ? pwdata[15:0] : div_q;
      wire        wide_nx = w_rt ? pwdata[`UBRG_RATE_WIDE] : wide;
      wire        smp_hit = (pre_q == smp_pt) & cnt_end &
                            (smp_q < 2'd3);
      wire        rx_in = receive_pin[g] ^ rate_q[`UBRG_RATE_RXINV];
      wire        maj = (vote_q[0] & vote_q[1]) | (vote_q[1] & vote_q[2]) |
                        (vote_q[0] & vote_q[2]);

      always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
          txsc_q <= `UBRG_TXSC_RST;
          rxsc_q <= `UBRG_RXSC_RST;
          rate_q <= `UBRG_RATE_RST;
          div_q  <= 16'h0000;
        end else begin
          if (w_tx) begin
            txsc_q <= (pwdata[7:0] & `UBRG_TXSC_WMASK) |
                      (txsc_q & ~`UBRG_TXSC_WMASK);
          end
          if (w_rx) begin
            rxsc_q <= (pwdata[7:0] & `UBRG_RXSC_WMASK) |
                      (rxsc_q & ~`UBRG_RXSC_WMASK);
          end
          if (w_rt) begin
            rate_q <= (pwdata[7:0] & `UBRG_RATE_WMASK) |
                      (rate_q & ~`UBRG_RATE_WMASK);
          end
          if (w_dv) begin
            div_q <= pwdata[15:0];
          end
        end
      end

      // Timer runs on the system clock itself
      always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
          cnt_q       <= 16'h0000;
          pre_q       <= 7'h00;
          smp_q       <= 2'd0;
          vote_q      <= 3'b111;
          rate_tick[g]   <= 1'b0;
          sample_tick[g] <= 1'b0;
          rx_level[g]    <= 1'b1;
        end else if (w_dv || w_rt || w_tx || !en) begin
          // Restart so the new rate applies at once
          cnt_q       <= wide_nx ? div_nx :
                         {8'h00, div_nx[7:0]};
          pre_q       <= 7'h00;
          smp_q       <= 2'd0;
          rate_tick[g]   <= 1'b0;
          sample_tick[g] <= 1'b0;
        end else begin
          sample_tick[g] <= smp_hit;
          if (smp_hit) begin
            vote_q <= {vote_q[1:0], rx_in};
            smp_q  <= smp_q + 2'd1;
          end
          if (pre_end) begin
            pre_q <= 7'h00;
            if (cnt_end) begin
              cnt_q        <= n;
              rate_tick[g] <= 1'b1;
              smp_q        <= 2'd0;
              rx_level[g]  <= maj;
            end else begin
              cnt_q        <= cnt_q - 16'h0001;
              rate_tick[g] <= 1'b0;
            end
          end else begin
            pre_q        <= pre_q + 7'h01;
            rate_tick[g] <= 1'b0;
          end
        end
      end

      assign txsc_v[g] = txsc_q;
      assign rxsc_v[g] = rxsc_q;
      assign rate_v[g] = rate_q;
      assign div_v[g]  = div_q;
    end
  endgenerate

  // ============================================================
  // Read data
  always @* begin
    prdata = 32'h00000000;
    if (is_pdis) begin
      prdata = {24'h000000, pdis_q};
    end else if (in_ports) begin
      case (reg_off)
        `UBRG_OFF_TXSC: prdata = {24'h000000, txsc_v[sel_port]};
        `UBRG_OFF_RXSC: prdata = {24'h000000, rxsc_v[sel_port]};
        `UBRG_OFF_RATE: prdata = {24'h000000, rate_v[sel_port]};
        `UBRG_OFF_DIVH: prdata = {16'h0000, div_v[sel_port]};
        default:        prdata = 32'h00000000;
      endcase
    end
  end

endmodule // ubrg_top

// *** verif/ubrg_remote.sv ***
// Remote serial partner driving the receive lines
`timescale 1ns/1ps
module ubrg_remote (
  input  wire logic       ref_clk,
  input  wire logic [1:0] level,
  output logic      [1:0] line
);
  // Rests high, as an idle serial line does
  initial line = 2'b11;
  always @(posedge ref_clk) line <= level;
endmodule // ubrg_remote

// *** verif/ubrg_checker.sv ***
// Port timing and bus checks for the rate generator
`timescale 1ns/1ps
module ubrg_checker #(parameter NUM_PORTS = 2) (
  input wire logic                 ref_clk,
  input wire logic                 reset,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [7:0]           paddr,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic [31:0]          prdata,
  input wire logic [NUM_PORTS-1:0] rate_tick,
  input wire logic [NUM_PORTS-1:0] sample_tick,
  input wire logic [NUM_PORTS-1:0] rx_level
);
  // ========
  // Checks
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  wire acc = psel && penable;
  // Samples seen by port 0 since its last tick or any write to a port 0 register
  logic [1:0] smp_cnt;
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      smp_cnt <= 2'd0;
    end else if ((acc && pwrite && paddr[7:4] == 4'h0) || rate_tick[0]) begin
      smp_cnt <= 2'd0;
    end else if (sample_tick[0] && smp_cnt != 2'd3) begin
      smp_cnt <= smp_cnt + 2'd1;
    end
  end
  a_three_samples: assert property (rate_tick[0] |-> smp_cnt == 2'd3)
    else $error("port0 bit not sampled three times");
  a_zero_wait: assert property (acc |-> pready)
    else $error("pready low in access");
  a_unmapped_err: assert property (acc && !pwrite && paddr > 8'h20 |->
    pslverr && prdata == 32'h0) else $error("unmapped read");
  a_div_mapped: assert property (acc && paddr == 8'h0C |-> !pslverr)
    else $error("divisor access refused");
  a_restart_p0: assert property (acc && pwrite && paddr == 8'h0C |->
    ##2 !rate_tick[0] [*2]) else $error("port0 tick after write");
  a_restart_p1: assert property (acc && pwrite && paddr == 8'h1C |->
    ##2 !rate_tick[1] [*2]) else $error("port1 tick after write");
  a_gap_p0: assert property (rate_tick[0] |=> !rate_tick[0] [*3])
    else $error("port0 ticks too close");
  a_gap_p1: assert property (rate_tick[1] |=> !rate_tick[1] [*3])
    else $error("port1 ticks too close");
  a_vote_p0: assert property ($changed(rx_level[0]) |->
    rate_tick[0] || $past(rate_tick[0])) else $error("level off tick");
  c_tick: cover property (rate_tick[1]);
  c_err: cover property (acc && pslverr);
  c_vote: cover property ($fell(rx_level[0]));
endmodule // ubrg_checker
bind ubrg_top ubrg_checker #(.NUM_PORTS(NUM_PORTS)) u_chk (.ref_clk,
  .reset, .psel, .penable, .pwrite, .paddr, .pready, .pslverr, .prdata,
  .rate_tick, .sample_tick, .rx_level);

// *** verif/ubrg_top_bench.sv ***
// Self-checking bench for the rate generator
`timescale 1ns/1ps
module ubrg_top_bench;
  logic        ref_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd;
  logic [1:0]  lvl = 2'b11;
  logic        er;
  wire         pready, pslverr;
  wire  [31:0] prdata;
  wire  [1:0]  rx_line, rate_tick, sample_tick, rx_level;
  int          miscompares = 0, n_checks = 0, c, i;
  logic [7:0]  rt [6] = '{8'h00, 8'h04, 8'h00, 8'h04, 8'h14, 8'h10};
  logic [7:0]  rr [6] = '{8'h00, 8'h00, 8'h08, 8'h08, 8'h00, 8'h08};
  logic [15:0] rv [6] = '{16'h0102, 16'h0102, 16'h0102,
                          16'h0102, 16'h0105, 16'h0003};
  int          rp [6] = '{192, 48, 4144, 1036, 24, 16};
  always #4 ref_clk = ~ref_clk;
  ubrg_remote u_remote (.ref_clk(ref_clk), .level(lvl), .line(rx_line));
  ubrg_top #(.NUM_PORTS(2)) dut (.ref_clk(ref_clk), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .receive_pin(rx_line), .rate_tick(rate_tick),
    .sample_tick(sample_tick), .rx_level(rx_level));
  // ========
  // Tasks
  task close_out;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    @(posedge ref_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge ref_clk) penable <= 1'b1;
    k = 0;
    do @(posedge ref_clk); while (pready !== 1'b1 && ++k < 9);
    if (k >= 9) begin miscompares++; close_out; end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Ticks are one cycle wide, so count edges until one is seen
  task per(input int p);
    c = 0;
    do begin @(posedge ref_clk); c++; end
    while (rate_tick[p] !== 1'b1 && c < 9000);
    if (c >= 9000) begin miscompares++; close_out; end
  endtask
  // ========
  // Sequence
  initial begin
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    apb(8'h00, 0, 32'h0);
    chk("tx_reset", rd, 32'h02);
    apb(8'h08, 0, 32'h0);
    chk("rate_reset", rd, 32'h40);
    chk("rx_reset", {30'h0, rx_level}, 32'h3);
    apb(8'h24, 0, 32'h0);
    chk("unmapped_err", {31'h0, er}, 32'h1);
    chk("unmapped_data", rd, 32'h0);
    $display("reset test done");
    apb(8'h04, 1, 32'h80);
    for (i = 0; i < 6; i++) begin
      apb(8'h00, 1, {24'h0, rt[i]});
      apb(8'h08, 1, {24'h0, rr[i]});
      apb(8'h0C, 1, {16'h0, rv[i]});
      per(0);
      per(0);
      chk("period", c, rp[i]);
    end
    $display("rate table done");
    apb(8'h0C, 1, 32'hFFFF);
    repeat (20) @(posedge ref_clk);
    apb(8'h0C, 1, 32'h0003);
    per(0);
    chk("restart", c, 17);
    apb(8'h14, 1, 32'h80);
    apb(8'h10, 1, 32'h10);
    apb(8'h1C, 1, 32'h0009);
    per(1);
    per(1);
    chk("period_p1", c, 40);
    lvl <= 2'b00;
    repeat (6) per(0);
    chk("vote_low", {30'h0, rx_level}, 32'h0);
    lvl <= 2'b11;
    repeat (6) per(0);
    chk("vote_high", {30'h0, rx_level}, 32'h3);
    $display("port tests done");
    close_out;
  end
endmodule // ubrg_top_bench
